// ==== skip_unit_consts.vh ====
// opcode fields and widths for the signed compare-and-skip unit
`ifndef SKIP_UNIT_CONSTS_VH
`define SKIP_UNIT_CONSTS_VH
`define OPC_HI_NIBBLE 4'hE
`define OPC_MID_NIBBLE 4'h6
`define OPC_SEL_NIBBLE 4'h1
`define OPC_HI_MSB 23
`define OPC_MID_MSB 19
`define OPC_DIR_BIT 15
`define OPC_SEL_MSB 7
`define OPC_ZERO_MSB 9
`define FLD_FIRST_MSB 14
`define FLD_FIRST_LSB 11
`define FLD_WIDTH_BIT 10
`define FLD_SECOND_MSB 3
`define FLD_SECOND_LSB 0
`define INSN_W 24
`define DATA_W 16
`define BYTE_W 8
`define PC_STEP_ONE 2
`define PC_STEP_TWO 4
`endif

// ==== signed_compare.v ====
// signed compare by subtraction at byte or word width
`timescale 1ns/1ns
`default_nettype none
module signed_compare #(
    parameter DATA_W = 16,
    parameter BYTE_W = 8
) (
    // operands
    input wire [DATA_W-1:0] op_a,
    input wire [DATA_W-1:0] op_b,
    input wire byte_mode,
    // results
    output wire a_gt_b,
    output wire a_lt_b
);
    wire [DATA_W:0] diff_w;
    wire [BYTE_W:0] diff_b;
    wire lt_w;
    wire lt_b;
    wire eq_w;
    wire eq_b;
    // sign-extended difference avoids overflow in the less-than test
    assign diff_w = {op_a[DATA_W-1], op_a} - {op_b[DATA_W-1], op_b};
    assign diff_b = {op_a[BYTE_W-1], op_a[BYTE_W-1:0]} - {op_b[BYTE_W-1], op_b[BYTE_W-1:0]};
    assign lt_w = diff_w[DATA_W];
    assign lt_b = diff_b[BYTE_W];
    assign eq_w = (diff_w == {(DATA_W+1){1'b0}});
    assign eq_b = (diff_b == {(BYTE_W+1){1'b0}});
    assign a_lt_b = byte_mode ? lt_b : lt_w;
    assign a_gt_b = byte_mode ? (~lt_b & ~eq_b) : (~lt_w & ~eq_w);
endmodule // signed_compare
`default_nettype wire

// ==== signed_compare_skip_unit.v ====
// decode and execute of the signed compare-and-skip instructions
// Operation
// - greater-than skip decodes from nibbles 1110, 0110, third nibble msb 0, selector 0001.
// - less-than skip decodes from nibbles 1110, 0110, third nibble msb 1, selector 0001.
// - greater-than compares the operands as signed two's-complement values.
// - less-than compares the operands as signed two's-complement values.
// - comparison is first minus second, result discarded, no register or flag written.
// - first signed-greater than second in greater-than form squashes the next instruction.
// - first signed-less than second in less-than form squashes the next instruction.
// - a squashed instruction is replaced by a no-operation in the following cycle.
// - a false condition lets the next instruction run with no squash or extra cycle.
// - width bit 0 selects word, 1 selects byte comparing only the low eight bits.
// - a four-bit field addresses the first operand among sixteen working registers.
// - the low four-bit field addresses the second operand among sixteen registers.
// - one word, one cycle when not skipping, two or three cycles when skipping.
`timescale 1ns/1ns
`default_nettype none
`include "skip_unit_consts.vh"
module signed_compare_skip_unit #(
    parameter DATA_W = `DATA_W,
    parameter INSN_W = `INSN_W
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // executing instruction
    input wire exec_valid,
    input wire [INSN_W-1:0] exec_insn,
    // register file read ports
    output wire [3:0] first_operand_register,
    output wire [3:0] second_operand_register,
    input wire [DATA_W-1:0] first_operand_data,
    input wire [DATA_W-1:0] second_operand_data,
    // prefetched instruction
    input wire next_two_word,
    // pipeline control
    output wire is_skip_insn,
    output wire squash_next,
    output reg [2:0] pc_skip_bytes_ff,
    output wire stall,
    output wire exec_nop_ff_out
);
    // one-hot phases of a taken skip: idle, first nop slot, second nop slot
    localparam ST_IDLE = 3'b001;
    localparam ST_SLOT1 = 3'b010;
    localparam ST_SLOT2 = 3'b100;
    // pc advance past the squashed follower, in bytes
    localparam [2:0] STEP_ONE_WORD = `PC_STEP_ONE;
    localparam [2:0] STEP_TWO_WORD = `PC_STEP_TWO;
    localparam [2:0] STEP_NONE = 3'h0;

    // phase and follower size
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg two_word_ff;
    reg nxt_two_word;
    // registered outputs
    reg nop_ff;
    reg nxt_nop;
    reg [2:0] nxt_skip_bytes;
    // instruction fields
    wire [3:0] opc_hi_field;
    wire [3:0] opc_mid_field;
    wire [3:0] opc_sel_field;
    wire [1:0] opc_zero_field;
    wire dir_bit;
    wire byte_mode;
    // decode and compare
    wire base_match;
    wire is_gt;
    wire is_lt;
    wire a_gt_b;
    wire a_lt_b;
    wire gt_hit;
    wire lt_hit;
    wire in_idle;
    wire take_skip;

    // four-bit register address at a given field position
    function [3:0] reg_field;
        input [INSN_W-1:0] insn;
        input integer lsb;
        begin
            reg_field = insn[lsb +: 4];
        end
    endfunction

    // fixed opcode bits shared by both variants
    function decode_base;
        input [3:0] hi;
        input [3:0] mid;
        input [3:0] sel;
        input [1:0] zero;
        begin
            decode_base = (hi == `OPC_HI_NIBBLE)
                && (mid == `OPC_MID_NIBBLE)
                && (sel == `OPC_SEL_NIBBLE)
                && (zero == 2'h0);
        end
    endfunction

    assign opc_hi_field = exec_insn[`OPC_HI_MSB -: 4];
    assign opc_mid_field = exec_insn[`OPC_MID_MSB -: 4];
    assign opc_sel_field = exec_insn[`OPC_SEL_MSB -: 4];
    assign opc_zero_field = exec_insn[`OPC_ZERO_MSB -: 2];
    assign dir_bit = exec_insn[`OPC_DIR_BIT];
    assign byte_mode = exec_insn[`FLD_WIDTH_BIT];
    // addresses go out every cycle; an unused read costs the register file nothing
    assign first_operand_register = reg_field(exec_insn, `FLD_FIRST_LSB);
    assign second_operand_register = reg_field(exec_insn, `FLD_SECOND_LSB);

    assign base_match = exec_valid
        && decode_base(opc_hi_field, opc_mid_field, opc_sel_field, opc_zero_field);
    assign is_gt = base_match && !dir_bit;
    assign is_lt = base_match && dir_bit;
    assign is_skip_insn = is_gt || is_lt;

    // no write port exists: the difference never leaves the comparator
    signed_compare #(
        .DATA_W(DATA_W),
        .BYTE_W(`BYTE_W)
    ) u_cmp (
        .op_a(first_operand_data),
        .op_b(second_operand_data),
        .byte_mode(byte_mode),
        .a_gt_b(a_gt_b),
        .a_lt_b(a_lt_b)
    );

    // a nop slot runs no instruction of its own, so no skip can start there
    assign in_idle = (state_ff == ST_IDLE);
    assign gt_hit = is_gt && a_gt_b;
    assign lt_hit = is_lt && a_lt_b;
    assign take_skip = in_idle && (gt_hit || lt_hit);
    assign squash_next = take_skip;
    // a two-word follower holds the fetch in the cycle the skip is taken, not in a nop slot
    assign stall = take_skip && next_two_word;
    assign exec_nop_ff_out = nop_ff;

    // next phase
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take_skip) begin
                    nxt_state = ST_SLOT1;
                end
            end
            ST_SLOT1: begin
                if (two_word_ff) begin
                    nxt_state = ST_SLOT2;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SLOT2: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                // an illegal code returns to idle instead of locking the decoder out
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // size of the squashed follower, kept for the second slot
    always @* begin
        nxt_two_word = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (take_skip) begin
                    nxt_two_word = next_two_word;
                end
            end
            ST_SLOT1: begin
                nxt_two_word = two_word_ff;
            end
            ST_SLOT2: begin
                nxt_two_word = 1'b0;
            end
            default: begin
                nxt_two_word = 1'b0;
            end
        endcase
    end

    // pc step, one cycle after the skip is taken
    always @* begin
        nxt_skip_bytes = STEP_NONE;
        case (state_ff)
            ST_IDLE: begin
                if (take_skip && next_two_word) begin
                    nxt_skip_bytes = STEP_TWO_WORD;
                end else if (take_skip) begin
                    nxt_skip_bytes = STEP_ONE_WORD;
                end
            end
            ST_SLOT1: begin
                nxt_skip_bytes = STEP_NONE;
            end
            ST_SLOT2: begin
                nxt_skip_bytes = STEP_NONE;
            end
            default: begin
                nxt_skip_bytes = STEP_NONE;
            end
        endcase
    end

    // every phase but idle is a nop slot
    always @* begin
        nxt_nop = (nxt_state != ST_IDLE);
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            two_word_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            two_word_ff <= nxt_two_word;
        end
    end

    // outputs stay registered so the pc adder sees a clean step
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            nop_ff <= 1'b0;
            pc_skip_bytes_ff <= STEP_NONE;
        end else begin
            nop_ff <= nxt_nop;
            pc_skip_bytes_ff <= nxt_skip_bytes;
        end
    end
endmodule // signed_compare_skip_unit
`default_nettype wire

// ==== skip_unit_monitor.sv ====
// concurrent checks on the compare-and-skip unit ports
`timescale 1ns/1ns
`default_nettype none
module skip_unit_monitor (
    // clock and reset
    input wire logic sys_clk, input wire logic rstn,
    // inputs
    input wire logic exec_valid, input wire logic [23:0] exec_insn,
    input wire logic [15:0] first_operand_data, input wire logic [15:0] second_operand_data,
    input wire logic next_two_word,
    // outputs
    input wire logic [3:0] first_operand_register, input wire logic [3:0] second_operand_register,
    input wire logic is_skip_insn, input wire logic squash_next, input wire logic stall,
    input wire logic [2:0] pc_skip_bytes_ff, input wire logic exec_nop_ff_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_first_field: assert property (first_operand_register == exec_insn[14:11])
        else $error("first operand field wrong");
    a_second_field: assert property (second_operand_register == exec_insn[3:0])
        else $error("second operand field wrong");
    a_decode_match: assert property (is_skip_insn |-> exec_insn[23:16] == 8'hE6 && exec_insn[9:4] == 6'h01)
        else $error("skip decoded from wrong opcode");
    a_squash_nop: assert property (squash_next |=> exec_nop_ff_out)
        else $error("no nop slot after squash");
    a_pc_one_word: assert property (squash_next && !next_two_word
        |=> pc_skip_bytes_ff == 3'h2 && exec_nop_ff_out ##1 !exec_nop_ff_out)
        else $error("pc step wrong for one-word follower");
    a_pc_two_word: assert property (squash_next && next_two_word
        |-> stall ##1 pc_skip_bytes_ff == 3'h4 && exec_nop_ff_out
        ##1 exec_nop_ff_out && pc_skip_bytes_ff == 3'h0 ##1 !exec_nop_ff_out)
        else $error("two-word skip timing wrong");
    // nop slots excluded: a skip still decodes there but cannot be taken in either one
    a_gt_signed: assert property (exec_valid && is_skip_insn && !exec_nop_ff_out && !exec_insn[15] && !exec_insn[10]
        |-> squash_next == ($signed(first_operand_data) > $signed(second_operand_data)))
        else $error("greater-than word compare wrong");
    a_lt_byte: assert property (exec_valid && is_skip_insn && !exec_nop_ff_out && exec_insn[15] && exec_insn[10]
        |-> squash_next == ($signed(first_operand_data[7:0]) < $signed(second_operand_data[7:0])))
        else $error("less-than byte compare wrong");
    a_squash_decoded: assert property (squash_next |-> is_skip_insn && !exec_nop_ff_out)
        else $error("squash without a decoded skip");
    a_pc_quiet: assert property (!squash_next |=> pc_skip_bytes_ff == 3'h0)
        else $error("pc step without a taken skip");
endmodule // skip_unit_monitor
bind signed_compare_skip_unit skip_unit_monitor skip_unit_monitor_i (.*);
`default_nettype wire

// ==== signed_compare_skip_unit_tb_top.sv ====
// directed testbench for the compare-and-skip unit
`timescale 1ns/1ns
`default_nettype none
module signed_compare_skip_unit_tb_top;
    logic sys_clk = 0, rstn = 0, exec_valid = 0, next_two_word = 0;
    logic [23:0] exec_insn = 24'h0;
    logic [15:0] a_data = 16'h0, b_data = 16'h0;
    wire [3:0] fr, sr;
    wire skip, sq, stall, nop;
    wire [2:0] pc;
    int mismatches = 0, checks = 0, cycles = 0;
    signed_compare_skip_unit signed_compare_skip_unit_i (.sys_clk(sys_clk), .rstn(rstn),
        .exec_valid(exec_valid), .exec_insn(exec_insn), .first_operand_register(fr),
        .second_operand_register(sr), .first_operand_data(a_data), .second_operand_data(b_data),
        .next_two_word(next_two_word), .is_skip_insn(skip), .squash_next(sq),
        .pc_skip_bytes_ff(pc), .stall(stall), .exec_nop_ff_out(nop));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // drive at the falling edge so the rising edge sees settled values
    task automatic issue(input logic dir, input logic b, input logic [15:0] x, input logic [15:0] y, input logic tw);
        @(negedge sys_clk);
        exec_valid = 1;
        exec_insn = {8'hE6, dir, 4'h3, b, 2'b00, 4'h1, 4'hC};
        a_data = x;
        b_data = y;
        next_two_word = tw;
        #10;
    endtask
    task automatic idle;
        @(negedge sys_clk);
        exec_valid = 0;
        exec_insn = 24'h0;
        next_two_word = 0;
    endtask
    task automatic s_gt_byte;
        issue(0, 1, 16'h00FF, 16'h26FE, 0);
        chk(16'(sq), 16'h1);
        chk(16'(skip), 16'h1);
        chk(16'(fr), 16'h3);
        chk(16'(sr), 16'hC);
        idle;
        chk(16'(nop), 16'h1);
        chk(16'(pc), 16'h2);
    endtask
    task automatic s_lt_two_word;
        issue(1, 0, 16'h2600, 16'h3000, 1);
        chk(16'(sq), 16'h1);
        chk(16'(stall), 16'h1);
        chk(16'(skip), 16'h1);
        idle;
        chk(16'(pc), 16'h4);
        chk(16'(nop), 16'h1);
        idle;
        chk(16'(nop), 16'h1);
        idle;
        chk(16'(nop), 16'h0);
    endtask
    task automatic s_no_skip;
        issue(1, 1, 16'h00FF, 16'h26FE, 0);
        chk(16'(sq), 16'h0);
        issue(0, 0, 16'h2600, 16'h2600, 0);
        chk(16'(sq), 16'h0);
        chk(16'(pc), 16'h0);
        chk(16'(nop), 16'h0);
        issue(0, 0, 16'h8000, 16'h7FFF, 0);
        chk(16'(sq), 16'h0);
        issue(0, 1, 16'h8000, 16'h7FFF, 0);
        chk(16'(sq), 16'h1);
        idle;
        idle;
    endtask
    task automatic s_decode;
        @(negedge sys_clk);
        exec_valid = 1;
        exec_insn = {8'hE6, 1'b0, 4'h3, 1'b0, 2'b00, 4'h0, 4'hC};
        a_data = 16'h0001;
        b_data = 16'h0000;
        #10;
        chk(16'(skip), 16'h0);
        chk(16'(sq), 16'h0);
        @(negedge sys_clk);
        exec_valid = 0;
        exec_insn = {8'hE6, 1'b0, 4'h3, 1'b0, 2'b00, 4'h1, 4'hC};
        #10;
        chk(16'(skip), 16'h0);
        chk(16'(sq), 16'h0);
        idle;
    endtask
    // reset in the middle of a two-word skip must leave the unit idle
    task automatic s_reset_mid;
        issue(0, 0, 16'h0001, 16'hFFFF, 1);
        chk(16'(sq), 16'h1);
        idle;
        chk(16'(nop), 16'h1);
        @(negedge sys_clk);
        rstn = 0;
        #10;
        chk(16'(nop), 16'h0);
        chk(16'(pc), 16'h0);
        @(negedge sys_clk);
        rstn = 1;
        issue(1, 0, 16'hFFFF, 16'h0001, 0);
        chk(16'(sq), 16'h1);
        idle;
        chk(16'(nop), 16'h1);
        chk(16'(pc), 16'h2);
        idle;
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop;
        end
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        rstn = 1;
        s_gt_byte;
        s_lt_two_word;
        s_no_skip;
        s_decode;
        s_reset_mid;
        report_and_stop;
    end
endmodule // signed_compare_skip_unit_tb_top
`default_nettype wire
